// >>> rtl/sdram_seq_defs.svh
// Offsets, field positions and reset values of the sequencer and address unit.
`ifndef SDRAM_SEQ_DEFS_SVH
`define SDRAM_SEQ_DEFS_SVH
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PROG_ADDR 8'h08
`define REG_PROG_DATA 8'h0c
`define REG_LOOP_COUNT 8'h10
`define REG_LAYER_SEL 8'h14
`define REG_LAYER_ROW 8'h18
`define REG_LAYER_WIDTH 8'h1c
`define REG_LAYER_FMT 8'h20
`define REG_LOGICAL 8'h24
`define REG_PHYSICAL 8'h28
`define CTRL_START_BIT 0
`define CTRL_BUSY_BIT 0
`define CTRL_PWRDN_BIT 1
`define WORD_ADDR_HI 12
`define WORD_ADDR_LO 6
`define WORD_FLOW_HI 5
`define WORD_FLOW_LO 4
`define WORD_FLOW_TOP 12
`define LOOP_COUNT_RESET 8'h01
`define ROW_LO 12
`endif

// >>> rtl/sdram_seq_pkg.sv
// Types shared by the sequencer, the array model and the bench.
package sdram_seq_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_BST = 3'h1, CMD_READ = 3'h2, CMD_WRITE = 3'h3,
    CMD_ACTIVATE = 3'h4, CMD_PRECHARGE_ALL = 3'h5, CMD_REFRESH = 3'h6,
    CMD_MODE_SET = 3'h7
  } sdram_cmd_t;
  typedef enum logic [2:0] {
    FLOW_RUN = 3'h0, FLOW_RET = 3'h1, FLOW_CALL = 3'h2, FLOW_LOOP = 3'h3,
    FLOW_PDE = 3'h6, FLOW_PDX = 3'h7
  } flow_t;
  typedef struct packed {
    logic rasN;
    logic casN;
    logic weN;
    logic autoPrecharge;
    logic valid;
  } sdram_pins_t;
endpackage

// >>> rtl/sdram_sequencer_address_map.sv
// Sequencer for init, refresh and power-down plus pixel address mapping.
`timescale 1ns/10ps
`include "sdram_seq_defs.svh"
module sdram_sequencer_address_map #(
  parameter int PROG_DEPTH = 64,
  parameter int LAYERS = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic genBusy,
  output sdram_seq_pkg::sdram_pins_t sdramCmd,
  output logic clockEnable
);
  import sdram_seq_pkg::*;

  localparam int AW = $clog2(PROG_DEPTH);

  initial
  begin
    if (PROG_DEPTH != 64 && PROG_DEPTH != 32)
      $error("PROG_DEPTH must be 64 or 32");
    if (LAYERS != 16)
      $error("LAYERS must be 16");
  end

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_RUN} seq_state_t;

  logic [12:0] progMem [PROG_DEPTH];
  logic [10:0] baseRowMem [LAYERS];
  logic [13:0] widthMem [LAYERS];
  logic [3:0] fmtMem [LAYERS];

  logic [AW-1:0] progAddr_ff;
  logic [7:0] loopLimit_ff;
  logic [3:0] layerSel_ff;
  logic [31:0] logical_ff;
  logic [31:0] physical_ff;
  logic startPending_ff;
  logic powerDown_ff;
  seq_state_t state_ff;
  logic [AW-1:0] pc_ff;
  logic [AW-1:0] retAddr_ff;
  logic [7:0] loopCnt_ff;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [7:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;

  // Write channel: address and data may arrive in either order.
  assign awready = !awHeld_ff && !bvalid;
  assign wready = !wHeld_ff && !bvalid;
  wire doWrite = awHeld_ff && wHeld_ff && !bvalid;
  wire wrFull = wStrb_ff == 4'hf;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready)
      begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddr_ff > `REG_PHYSICAL || awAddr_ff[1:0] != 2'h0)
          ? 2'h2 : 2'h0;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Software registers; writes take effect only with all byte lanes set.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      progAddr_ff <= '0;
      loopLimit_ff <= `LOOP_COUNT_RESET;
      layerSel_ff <= 4'h0;
      logical_ff <= 32'h00000000;
    end
    else if (doWrite && wrFull)
    begin
      case (awAddr_ff)
        `REG_PROG_ADDR: progAddr_ff <= wData_ff[AW-1:0];
        `REG_PROG_DATA: progAddr_ff <= progAddr_ff + 1'b1;
        `REG_LOOP_COUNT: loopLimit_ff <= wData_ff[7:0];
        `REG_LAYER_SEL: layerSel_ff <= wData_ff[3:0];
        `REG_LOGICAL: logical_ff <= wData_ff;
        default: ;
      endcase
    end
  end

  // Program and layer stores.
  always_ff @(posedge mclk)
  begin
    if (doWrite && wrFull)
    begin
      if (awAddr_ff == `REG_PROG_DATA)
        progMem[progAddr_ff] <= {wData_ff[12:4], wData_ff[3:1], 1'b0};
      if (awAddr_ff == `REG_LAYER_ROW)
        baseRowMem[layerSel_ff] <= wData_ff[22:12];
      if (awAddr_ff == `REG_LAYER_WIDTH)
        widthMem[layerSel_ff] <= wData_ff[13:0];
      if (awAddr_ff == `REG_LAYER_FMT)
        fmtMem[layerSel_ff] <= wData_ff[3:0];
    end
  end

  // Start request: set wins over the clear taken when the routine starts.
  wire startWrite = doWrite && wrFull && awAddr_ff == `REG_CTRL &&
    wData_ff[`CTRL_START_BIT];
  wire launch = state_ff != SEQ_RUN && startPending_ff && !genBusy;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      startPending_ff <= 1'b0;
    else if (startWrite)
      startPending_ff <= 1'b1;
    else if (launch)
      startPending_ff <= 1'b0;
  end

  // Micro program decode.
  wire [12:0] word = progMem[pc_ff];
  wire [AW-1:0] argAddr = word[`WORD_ADDR_LO+AW-1:`WORD_ADDR_LO];
  // Two instruction bits cannot hold six flow codes, so the spare top bit
  // above the argument supplies the flow code's upper bit.
  wire [2:0] flowBits = {word[`WORD_FLOW_TOP],
    word[`WORD_FLOW_HI:`WORD_FLOW_LO]};
  wire [2:0] cmdBits = word[3:1];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= SEQ_IDLE;
      pc_ff <= '0;
      retAddr_ff <= '0;
      loopCnt_ff <= 8'h00;
      powerDown_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        SEQ_IDLE, SEQ_WAIT:
        begin
          if (launch)
          begin
            state_ff <= SEQ_RUN;
            pc_ff <= '0;
            loopCnt_ff <= 8'h00;
          end
          else if (startPending_ff)
            state_ff <= SEQ_WAIT;
        end
        SEQ_RUN:
        begin
          case (flow_t'(flowBits))
            FLOW_RET: pc_ff <= retAddr_ff;
            FLOW_CALL:
            begin
              retAddr_ff <= pc_ff + 1'b1;
              pc_ff <= argAddr;
            end
            FLOW_LOOP:
            begin
              if (loopCnt_ff + 8'h01 >= loopLimit_ff)
              begin
                loopCnt_ff <= 8'h00;
                if (argAddr == '0)
                  state_ff <= SEQ_IDLE;
                else
                  pc_ff <= pc_ff + 1'b1;
              end
              else
              begin
                loopCnt_ff <= loopCnt_ff + 8'h01;
                pc_ff <= argAddr;
              end
            end
            FLOW_PDE:
            begin
              powerDown_ff <= 1'b1;
              pc_ff <= pc_ff + 1'b1;
            end
            FLOW_PDX:
            begin
              powerDown_ff <= 1'b0;
              pc_ff <= pc_ff + 1'b1;
            end
            default: pc_ff <= pc_ff + 1'b1;
          endcase
        end
        default: state_ff <= SEQ_IDLE;
      endcase
    end
  end

  // Command output from flip-flops, inverted to active-low pins.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      sdramCmd <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, autoPrecharge: 1'b0,
        valid: 1'b0};
    else if (state_ff == SEQ_RUN)
      sdramCmd <= '{rasN: !cmdBits[2], casN: !cmdBits[1], weN: !cmdBits[0],
        autoPrecharge: 1'b0, valid: 1'b1};
    else
      sdramCmd <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1, autoPrecharge: 1'b0,
        valid: 1'b0};
  end

  assign clockEnable = !powerDown_ff;

  // Address unit: logical word to physical address.
  wire [3:0] layer = {logical_ff[31:30], logical_ff[15:14]};
  wire [13:0] posX = logical_ff[29:16];
  wire [13:0] posY = logical_ff[13:0];
  wire [3:0] fmt = fmtMem[layer];
  logic [2:0] shift;

  always_comb
  begin
    case (fmt)
      4'h0, 4'h1, 4'h2, 4'h3: shift = fmt[2:0];
      4'h4, 4'h5, 4'h7: shift = 3'h4;
      4'h6, 4'h8, 4'he, 4'hf: shift = 3'h5;
      default: shift = 3'h0;
    endcase
  end

  wire [18:0] lineBits = 19'(widthMem[layer]) << shift;
  wire [10:0] rowCount = {1'b0, lineBits[18:9]} +
    11'(|lineBits[8:0]);
  wire [18:0] shiftedX = 19'(posX) << shift;
  wire [10:0] rowAddr = 11'(posY[13:6] * rowCount) +
    {1'b0, shiftedX[18:9]} + baseRowMem[layer];
  wire [1:0] bankAddr = {posY[5], shiftedX[8]};
  wire [7:0] colAddr = {posY[4:0], shiftedX[7:5]};

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      physical_ff <= 32'h00000000;
    else
      physical_ff <= {9'h000, rowAddr, bankAddr, colAddr, 2'h0};
  end

  // Read channel.
  assign arready = !rvalid;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= 2'h0;
      case (araddr)
        `REG_STATUS: rdata <= {30'h0, powerDown_ff, state_ff != SEQ_IDLE};
        `REG_PROG_ADDR: rdata <= 32'(progAddr_ff);
        `REG_LOOP_COUNT: rdata <= {24'h0, loopLimit_ff};
        `REG_LAYER_SEL: rdata <= {28'h0, layerSel_ff};
        `REG_LAYER_ROW: rdata <= {9'h0, baseRowMem[layerSel_ff], 12'h000};
        `REG_LAYER_WIDTH: rdata <= {18'h0, widthMem[layerSel_ff]};
        `REG_LAYER_FMT: rdata <= {28'h0, fmtMem[layerSel_ff]};
        `REG_LOGICAL: rdata <= logical_ff;
        `REG_PHYSICAL: rdata <= physical_ff;
        `REG_CTRL, `REG_PROG_DATA: rdata <= 32'h00000000;
        default:
        begin
          rdata <= 32'h00000000;
          rresp <= 2'h2;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  chk_ap_zero: assert property (@(posedge mclk) disable iff (!nrst)
    !sdramCmd.autoPrecharge) else $error("auto precharge set");
  chk_wait_busy: assert property (@(posedge mclk) disable iff (!nrst)
    (state_ff == SEQ_WAIT && genBusy) |=> state_ff != SEQ_RUN)
    else $error("routine started during transfer");
  chk_cmd_invert: assert property (@(posedge mclk) disable iff (!nrst)
    state_ff == SEQ_RUN |=> sdramCmd.valid &&
    {sdramCmd.rasN, sdramCmd.casN, sdramCmd.weN} == ~$past(cmdBits))
    else $error("command not inverted");
  chk_call_ret: assert property (@(posedge mclk) disable iff (!nrst)
    (state_ff == SEQ_RUN && flowBits == 3'h2) |=>
    pc_ff == $past(argAddr) && retAddr_ff == $past(pc_ff) + 1'b1)
    else $error("call target wrong");
  chk_pde: assert property (@(posedge mclk) disable iff (!nrst)
    (state_ff == SEQ_RUN && flowBits == 3'h6) |=> !clockEnable)
    else $error("power down not entered");
  chk_pdx: assert property (@(posedge mclk) disable iff (!nrst)
    (state_ff == SEQ_RUN && flowBits == 3'h7) |=> clockEnable)
    else $error("power down not left");
  chk_start_run: assert property (@(posedge mclk) disable iff (!nrst)
    launch |=> state_ff == SEQ_RUN && pc_ff == '0)
    else $error("launch failed");
  chk_phys_low: assert property (@(posedge mclk) disable iff (!nrst)
    physical_ff[1:0] == 2'h0 && physical_ff[31:23] == 9'h000)
    else $error("physical format wrong");
  chk_bank_map: assert property (@(posedge mclk) disable iff (!nrst)
    (doWrite && wrFull && awAddr_ff == `REG_LOGICAL) ##1 1'b1 |=>
    physical_ff[11:10] == $past({posY[5], shiftedX[8]}))
    else $error("bank bits wrong");
  cov_launch: cover property (@(posedge mclk) disable iff (!nrst) launch);
  cov_wait: cover property (@(posedge mclk) disable iff (!nrst)
    state_ff == SEQ_WAIT ##1 state_ff == SEQ_RUN);
  cov_pd: cover property (@(posedge mclk) disable iff (!nrst)
    !clockEnable ##[1:50] clockEnable);
endmodule

// >>> test/sdram_array_model.sv
// Behavioural memory array that watches the command bus.
`timescale 1ns/10ps
module sdram_array_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire sdram_seq_pkg::sdram_pins_t sdramCmd,
  output int cmdCount,
  output int refreshCount,
  output int badCount
);
  import sdram_seq_pkg::*;
  sdram_cmd_t code;
  logic [2:0] pins;
  assign pins = {sdramCmd.rasN, sdramCmd.casN, sdramCmd.weN};
  assign code = sdram_cmd_t'(~pins);
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmdCount <= 0;
      refreshCount <= 0;
      badCount <= 0;
    end
    else if (sdramCmd.valid)
    begin
      cmdCount <= cmdCount + 1;
      if (code == CMD_REFRESH)
        refreshCount <= refreshCount + 1;
      // Data transfers have no data path here, so they count as faults.
      if (sdramCmd.autoPrecharge || code inside {CMD_ACTIVATE, CMD_WRITE,
          CMD_READ, CMD_BST})
        badCount <= badCount + 1;
    end
  end
endmodule

// >>> test/sdram_sequencer_address_map_bench.sv
// Bench for the command sequencer and the pixel address unit.
`timescale 1ns/10ps
`include "sdram_seq_defs.svh"
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
    end \
  end
module sdram_sequencer_address_map_bench;
  import sdram_seq_pkg::*;
  logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready, genBusy;
  logic awready, wready, bvalid, arready, rvalid, clockEnable;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [13:0] x;
  sdram_pins_t sdramCmd;
  int cmdCount, refreshCount, badCount, fail_count, tests_run;
  sdram_cmd_t seq [3] = '{CMD_MODE_SET, CMD_REFRESH, CMD_PRECHARGE_ALL};
  // Mode set, call with refresh, power down, end; the subroutine
  // issues precharge all and returns.
  logic [31:0] prog [5] = '{32'h0e, 32'h12c, 32'h1020, 32'h30, 32'h1a};

  sdram_sequencer_address_map i_dut (.mclk(mclk), .nrst(nrst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .genBusy(genBusy), .sdramCmd(sdramCmd),
    .clockEnable(clockEnable));
  sdram_array_model i_mem (.mclk(mclk), .nrst(nrst), .sdramCmd(sdramCmd),
    .cmdCount(cmdCount), .refreshCount(refreshCount), .badCount(badCount));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [2:0] shiftOf(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: return c[2:0];
      4'h4, 4'h5, 4'h7: return 3'h4;
      4'h6, 4'h8, 4'he, 4'hf: return 3'h5;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] expPhys(input logic [10:0] b,
    input logic [13:0] w, input logic [3:0] c, input logic [13:0] px, y);
    logic [31:0] lb, xs;
    logic [10:0] rows, ra;
    lb = 32'(w) << shiftOf(c);
    xs = 32'(px) << shiftOf(c);
    rows = 11'(lb[18:9]) + 11'(|lb[8:0]);
    ra = 11'(y[13:6] * rows) + 11'(xs[18:9]);
    return {9'h0, 11'(b + ra), y[5], xs[8], y[4:0], xs[7:5], 2'h0};
  endfunction

  // Ready and valid are sampled mid-cycle, where they are settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] resp);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb)
    begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (tb)
        bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] resp);
    logic ta, tr;
    tr = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr)
    begin
      @(negedge mclk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge mclk);
      if (ta)
        arvalid <= 1'b0;
      if (tr)
        rready <= 1'b0;
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] resp;
    wr(a, v, resp);
    `CHK(resp, 2'h0)
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, 2'h0)
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, genBusy} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    wstrb = 4'hf;
    nrst = 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    `CHK(clockEnable, 1'b1)
    `CHK(sdramCmd.valid, 1'b0)
    rchk(`REG_LOOP_COUNT, 32'h1);
    rd(8'h2c, d, r);
    `CHK(r, 2'h2)
    wr(8'h2c, 32'h0, r);
    `CHK(r, 2'h2)
    $display("test reset and bus done");
    w(`REG_LAYER_SEL, 32'h5);
    w(`REG_LAYER_ROW, 32'hffffffff);
    rchk(`REG_LAYER_ROW, 32'h007ff000);
    w(`REG_LAYER_ROW, 32'h00012000);
    w(`REG_LAYER_WIDTH, 32'd100);
    for (int c = 0; c < 16; c++)
    begin
      x = 14'(37 + c * 41);
      w(`REG_LAYER_FMT, 32'(c));
      w(`REG_LOGICAL, {2'h1, x, 2'h1, 14'h1a5});
      rchk(`REG_PHYSICAL, expPhys(11'h12, 14'd100, 4'(c), x, 14'h1a5));
    end
    w(`REG_LAYER_SEL, 32'ha);
    w(`REG_LAYER_ROW, 32'h00300000);
    w(`REG_LAYER_WIDTH, 32'd640);
    w(`REG_LAYER_FMT, 32'h3);
    w(`REG_LOGICAL, {2'h2, 14'd300, 2'h2, 14'h3c7});
    rchk(`REG_PHYSICAL, expPhys(11'h300, 14'd640, 4'h3, 14'd300, 14'h3c7));
    $display("test mapping done");
    w(`REG_PROG_ADDR, 32'h0);
    for (int c = 0; c < 64; c++)
      w(`REG_PROG_DATA, c < 5 ? prog[c] : 32'h0);
    genBusy <= 1'b1;
    w(`REG_CTRL, 32'h1);
    repeat (8) @(posedge mclk);
    `CHK(cmdCount, 0)
    genBusy <= 1'b0;
    @(negedge mclk);
    while (sdramCmd.valid !== 1'b1)
      @(negedge mclk);
    foreach (seq[k])
    begin
      `CHK(sdramCmd.valid, 1'b1)
      `CHK({sdramCmd.rasN, sdramCmd.casN, sdramCmd.weN}, ~seq[k])
      `CHK(sdramCmd.autoPrecharge, 1'b0)
      @(negedge mclk);
    end
    `CHK(refreshCount, 1)
    repeat (4) @(negedge mclk);
    `CHK(clockEnable, 1'b0)
    rd(`REG_STATUS, d, r);
    `CHK(d[1], 1'b1)
    `CHK(d[0], 1'b0)
    `CHK(badCount, 0)
    $display("test sequencer done");
    tally_and_finish();
  end
endmodule
